// *** rtl/dpa_params.svh ***
// Constants for the digital pattern alarm block: offsets, fields, resets
`ifndef DPA_PARAMS_SVH
`define DPA_PARAMS_SVH

`define DPA_NUM_CH        4
`define DPA_CH_W          2
`define DPA_ADDR_W        8

// Register offsets: channel fields at byte address 16 * channel + field offset; the last three are global
`define DPA_OFS_ALARM     8'h00
`define DPA_OFS_MASK      8'h04
`define DPA_OFS_CTRL      8'h08
`define DPA_OFS_CMD       8'h0C
`define DPA_OFS_IRQ_STAT  8'h40
`define DPA_OFS_IRQ_MASK  8'h44
`define DPA_OFS_FLAGS     8'h48

// Control register fields
`define DPA_CTRL_EN_BIT   0
`define DPA_CTRL_NEQ_BIT  1
`define DPA_CTRL_WID_LSB  2
`define DPA_CTRL_WID_MSB  3

// Width codes
`define DPA_WID_8         2'h0
`define DPA_WID_16        2'h1
`define DPA_WID_32        2'h2

// Command register codes
`define DPA_CMD_FACTORY   32'h0000_0001
`define DPA_CMD_PRESET    32'h0000_0002
`define DPA_CMD_CARD      32'h0000_0003

// Reset values
`define DPA_RST_WORD      32'h0000_0000
`define DPA_RST_CTRL      4'h0

`endif

// *** rtl/dpa_pkg.sv ***
// Types shared by the digital pattern alarm block
package dpa_pkg;
  typedef enum logic [1:0] {
    DPA_W8  = 2'b00,
    DPA_W16 = 2'b01,
    DPA_W32 = 2'b10
  } dpa_width_t;
  typedef logic [31:0] dpa_word_t;
endpackage

// *** rtl/dpa_cmp_if.sv ***
// Interface carrying one channel's settings and comparison result
`timescale 1ns/1ps
`default_nettype none
interface dpa_cmp_if;
  logic [31:0] alarm;
  logic [31:0] mask;
  logic        enable;
  logic        neq;
  logic [31:0] din;
  logic        alarm_flag;
  modport ctrl (output alarm, output mask, output enable, output neq, output din,
                input alarm_flag);
  modport cmp  (input alarm, input mask, input enable, input neq, input din,
                output alarm_flag);
endinterface
`default_nettype wire

// *** rtl/dpa_channel_cmp.sv ***
// One channel's masked pattern comparator with a registered alarm flag
`timescale 1ns/1ps
`default_nettype none
`include "dpa_params.svh"
module dpa_channel_cmp (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Channel settings and input
  dpa_cmp_if.cmp    cmp
);
  wire logic [31:0] diff_bits;
  wire logic        matched;
  wire logic        next_flag;

  assign diff_bits = (cmp.din ^ cmp.alarm) & cmp.mask;
  assign matched   = (diff_bits == 32'h0000_0000);
  assign next_flag = cmp.enable & (cmp.neq ? ~matched : matched);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmp.alarm_flag <= 1'b0;
    end else begin
      cmp.alarm_flag <= next_flag;
    end
  end

  flag_lag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(next_flag) == cmp.alarm_flag)
    else $error("alarm flag does not follow its condition by one cycle");
  disabled_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !cmp.enable ##1 !cmp.enable |-> !cmp.alarm_flag)
    else $error("alarm raised on a disabled channel");
  masked_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmp.enable && !cmp.neq && ((cmp.din ^ cmp.alarm) & cmp.mask) == 32'h0000_0000)
    |=> cmp.alarm_flag)
    else $error("masked equal pattern missed");
  neq_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmp.enable && cmp.neq && ((cmp.din ^ cmp.alarm) & cmp.mask) != 32'h0000_0000)
    |=> cmp.alarm_flag)
    else $error("differing pattern missed in not-equal mode");
  eq_alarm_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    cmp.enable && !cmp.neq ##1 cmp.alarm_flag);
  neq_alarm_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    cmp.enable && cmp.neq ##1 cmp.alarm_flag);
endmodule
`default_nettype wire

// *** rtl/dpa_top.sv ***
// Digital pattern alarm: per-channel settings, register port and interrupt
//
// Contract
// - Each digital input channel keeps an alarm value sized to its 8/16/32 width.
// - Written alarm values keep only the low bits fitting the channel width.
// - Written masks are truncated to the channel width like the alarm value.
// - Only input bits whose mask bit is 1 take part in comparison.
// - Factory reset zeroes alarm value and mask and disables comparison everywhere.
// - Instrument preset or card reset leaves alarm, mask and enable unchanged.
// - Comparison works on every channel regardless of scan list membership.
// - Alarm readback returns the stored truncated value, unsigned.
// - Equal mode alarms on masked match; differs mode alarms on mismatch.
// - A channel is monitored and compared only while its enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "dpa_params.svh"
module dpa_top (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // Register port
  input  wire logic [`DPA_ADDR_W-1:0]  i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  // Digital input channels
  input  wire logic [31:0]             i_digital_input_channel [`DPA_NUM_CH],
  // Alarm outputs
  output logic      [`DPA_NUM_CH-1:0]  o_alarm,
  output logic                         o_irq
);
  localparam int NCH = `DPA_NUM_CH;

  // ------------------------------------------------------------
  // Settings storage
  // ------------------------------------------------------------
  logic [31:0]     alarm_val [NCH];
  logic [31:0]     mask_val  [NCH];
  logic [3:0]      ctrl      [NCH];
  logic [NCH-1:0]  irq_stat;
  logic [NCH-1:0]  irq_mask;
  logic [NCH-1:0]  flag_q;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire logic [3:0]            fld_ofs;
  wire logic [`DPA_CH_W-1:0]  ch_sel;
  wire logic                  ch_space;
  wire logic                  wr_alarm;
  wire logic                  wr_mask;
  wire logic                  wr_ctrl;
  wire logic                  wr_cmd;
  wire logic                  factory_cmd;
  wire logic                  rd_stat;
  wire logic [31:0]           width_keep;

  assign fld_ofs     = i_addr[3:0];
  assign ch_sel      = i_addr[`DPA_CH_W+3:4];
  assign ch_space    = (i_addr < `DPA_OFS_IRQ_STAT);
  assign wr_alarm    = i_wr & ch_space & (fld_ofs == `DPA_OFS_ALARM);
  assign wr_mask     = i_wr & ch_space & (fld_ofs == `DPA_OFS_MASK);
  assign wr_ctrl     = i_wr & ch_space & (fld_ofs == `DPA_OFS_CTRL);
  assign wr_cmd      = i_wr & ch_space & (fld_ofs == `DPA_OFS_CMD);
  // Command code is global: any channel's command slot reaches every channel
  assign factory_cmd = wr_cmd & (i_wdata == `DPA_CMD_FACTORY);
  assign rd_stat     = i_rd & (i_addr == `DPA_OFS_IRQ_STAT);

  // Width of the addressed channel, taken from its stored control field
  function automatic logic [31:0] width_mask(input logic [1:0] w);
    unique case (dpa_pkg::dpa_width_t'(w))
      dpa_pkg::DPA_W8:  width_mask = 32'h0000_00FF;
      dpa_pkg::DPA_W16: width_mask = 32'h0000_FFFF;
      default:          width_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  assign width_keep = width_mask(ctrl[ch_sel][`DPA_CTRL_WID_MSB:`DPA_CTRL_WID_LSB]);

  // ------------------------------------------------------------
  // Per-channel settings and comparators
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire logic         sel;
      wire logic [31:0]  keep;
      dpa_cmp_if         link ();

      assign sel  = (ch_sel == `DPA_CH_W'(g));
      assign keep = width_mask(ctrl[g][`DPA_CTRL_WID_MSB:`DPA_CTRL_WID_LSB]);

      // Settings stay masked to the width so a later narrower width does not compare stored high bits
      assign link.alarm  = alarm_val[g] & keep;
      assign link.mask   = mask_val[g] & keep;
      assign link.enable = ctrl[g][`DPA_CTRL_EN_BIT];
      assign link.neq    = ctrl[g][`DPA_CTRL_NEQ_BIT];
      assign link.din    = i_digital_input_channel[g] & keep;
      assign flag_q[g]   = link.alarm_flag;

      always_ff @(posedge i_clk) begin
        if (!i_rst_n || factory_cmd) begin
          alarm_val[g] <= `DPA_RST_WORD;
          mask_val[g]  <= `DPA_RST_WORD;
          ctrl[g]      <= `DPA_RST_CTRL;
        end else begin
          // Preset and card reset fall through here and change nothing
          if (wr_alarm && sel) begin
            alarm_val[g] <= i_wdata & keep;
          end
          if (wr_mask && sel) begin
            mask_val[g] <= i_wdata & keep;
          end
          if (wr_ctrl && sel) begin
            ctrl[g] <= i_wdata[3:0];
          end
        end
      end

      dpa_channel_cmp u_cmp (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .cmp     (link)
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  // A new alarm in the clearing read's cycle survives the clear
  wire logic [NCH-1:0] rise;
  wire logic [NCH-1:0] next_stat;
  logic      [NCH-1:0] flag_d;

  assign rise      = flag_q & ~flag_d;
  assign next_stat = (rd_stat ? '0 : irq_stat) | rise;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flag_d   <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      flag_d   <= flag_q;
      irq_stat <= next_stat;
      if (i_wr && i_addr == `DPA_OFS_IRQ_MASK) begin
        irq_mask <= i_wdata[NCH-1:0];
      end
    end
  end

  assign o_alarm = flag_q;
  assign o_irq   = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ch_space) begin
      unique case (fld_ofs)
        `DPA_OFS_ALARM: rd_mux = alarm_val[ch_sel] & width_keep;
        `DPA_OFS_MASK:  rd_mux = mask_val[ch_sel] & width_keep;
        `DPA_OFS_CTRL:  rd_mux = {28'h000_0000, ctrl[ch_sel]};
        default:        rd_mux = 32'h0000_0000;
      endcase
    end else if (i_addr == `DPA_OFS_IRQ_STAT) begin
      rd_mux = {{(32-NCH){1'b0}}, irq_stat};
    end else if (i_addr == `DPA_OFS_IRQ_MASK) begin
      rd_mux = {{(32-NCH){1'b0}}, irq_mask};
    end else if (i_addr == `DPA_OFS_FLAGS) begin
      rd_mux = {{(32-NCH){1'b0}}, flag_q};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  alarm_trunc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_alarm && !factory_cmd && ch_sel == 0 &&
     ctrl[0][`DPA_CTRL_WID_MSB:`DPA_CTRL_WID_LSB] == `DPA_WID_8)
    |=> alarm_val[0] == ($past(i_wdata) & 32'h0000_00FF))
    else $error("alarm value not cut to 8 bits");
  mask_trunc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_mask && ch_sel == 0 &&
     ctrl[0][`DPA_CTRL_WID_MSB:`DPA_CTRL_WID_LSB] == `DPA_WID_16)
    |=> mask_val[0] == ($past(i_wdata) & 32'h0000_FFFF))
    else $error("mask not cut to 16 bits");
  factory_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    factory_cmd |=> alarm_val[0] == 32'h0000_0000 && mask_val[0] == 32'h0000_0000
                    && !ctrl[0][`DPA_CTRL_EN_BIT])
    else $error("factory reset left settings behind");
  preset_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_cmd && i_wdata != `DPA_CMD_FACTORY) |=>
    ctrl[0] == $past(ctrl[0]) && alarm_val[0] == $past(alarm_val[0]))
    else $error("preset changed settings");
  readback_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rd && ch_space && fld_ofs == `DPA_OFS_ALARM && !i_wr) |=>
    o_rdata == ($past(alarm_val[ch_sel]) & $past(width_keep)))
    else $error("alarm readback differs from stored value");
  irq_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_alarm[0]) |=> irq_stat[0])
    else $error("alarm rise did not set its status bit");
  width_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ctrl[0][`DPA_CTRL_WID_MSB:`DPA_CTRL_WID_LSB] == `DPA_WID_8 |->
    (g_ch[0].link.alarm & 32'hFFFF_FF00) == 32'h0000_0000)
    else $error("8-bit channel compares high bits");
  factory_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) factory_cmd);
  irq_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_irq ##1 rd_stat);
endmodule
`default_nettype wire

// *** bench/dpa_input_model.sv ***
// Behavioural model of the monitored digital input lines
`timescale 1ns/1ps
`default_nettype none
`include "dpa_params.svh"
module dpa_input_model (
  // Clock
  input  wire logic        i_clk,
  // Commanded patterns and channel widths
  input  wire logic [31:0] i_pat [`DPA_NUM_CH],
  input  wire logic [1:0]  i_wid [`DPA_NUM_CH],
  // Lines into the block
  output logic      [31:0] o_lines [`DPA_NUM_CH]
);
  logic [31:0] junk = 32'h5A5A_5A5A;
  logic [31:0] keep [`DPA_NUM_CH];
  always_comb begin
    for (int c = 0; c < `DPA_NUM_CH; c++) begin
      keep[c] = (i_wid[c] == 2'h0) ? 32'h0000_00FF :
                (i_wid[c] == 2'h1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    end
  end
  // Lines above the channel width float: they flicker every cycle
  always @(posedge i_clk) begin
    junk <= ~junk;
    for (int c = 0; c < `DPA_NUM_CH; c++) o_lines[c] <= (i_pat[c] & keep[c]) | (junk & ~keep[c]);
  end
endmodule
`default_nettype wire

// *** bench/tb_digital_pattern_alarm.sv ***
// Self-checking testbench for the digital pattern alarm block
`timescale 1ns/1ps
`default_nettype none
`include "dpa_params.svh"
module tb_digital_pattern_alarm;
  localparam logic [31:0] ALV = 32'hA5C3_F19A;
  localparam logic [31:0] MKV = 32'h8001_0181;
  logic                   i_clk   = 1'b0;
  logic                   i_rst_n = 1'b0;
  logic [`DPA_ADDR_W-1:0] i_addr  = 8'h00;
  logic [31:0]            i_wdata = 32'h0000_0000;
  logic                   i_wr    = 1'b0;
  logic                   i_rd    = 1'b0;
  logic [31:0]            o_rdata;
  logic [`DPA_NUM_CH-1:0] o_alarm;
  logic                   o_irq;
  logic [31:0]            lines [`DPA_NUM_CH];
  logic [31:0]            pat   [`DPA_NUM_CH];
  logic [1:0]             wid   [`DPA_NUM_CH];
  int                     mismatches  = 0;
  int                     check_count = 0;
  int                     cycles      = 0;

  dpa_top i_dpa_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_digital_input_channel(lines),
    .o_alarm(o_alarm), .o_irq(o_irq));
  dpa_input_model i_dpa_input_model (.i_clk(i_clk), .i_pat(pat), .i_wid(wid), .o_lines(lines));

  always #5 i_clk = ~i_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Tests take about 130 cycles; the ceiling leaves ample room
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(n, e, o_rdata);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  function automatic logic [7:0] ra(input int c, input logic [7:0] o);
    return 8'(c * 16) + o;
  endfunction
  function automatic logic [31:0] wm(input int c);
    return (c == 0) ? 32'h0000_00FF : (c == 1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int c = 0; c < `DPA_NUM_CH; c++) begin
      pat[c] = 32'h0000_0000;
      wid[c] = 2'h0;
    end
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(ra(3, `DPA_OFS_MASK), 32'h0000_0000, "mask after reset");
    chk("alarm after reset", 32'h0, {28'h0, o_alarm});
    // Every channel, width code equal to its index; a bit outside the mask differs
    for (int c = 0; c < `DPA_NUM_CH; c++) begin
      wid[c] <= 2'(c);
      pat[c] <= ALV ^ 32'h0000_0002;
      wr(ra(c, `DPA_OFS_CTRL), {28'h000_0000, 2'(c), 2'b00});
      wr(ra(c, `DPA_OFS_ALARM), ALV);
      wr(ra(c, `DPA_OFS_MASK), MKV);
      rd(ra(c, `DPA_OFS_ALARM), ALV & wm(c), "stored alarm");
      rd(ra(c, `DPA_OFS_MASK), MKV & wm(c), "stored mask");
    end
    tick(4);
    chk("alarm while disabled", 32'h0, {28'h0, o_alarm});
    for (int c = 0; c < `DPA_NUM_CH; c++) wr(ra(c, `DPA_OFS_CTRL), {28'h000_0000, 2'(c), 2'b01});
    tick(4);
    chk("alarm equal mode", 32'hF, {28'h0, o_alarm});
    rd(`DPA_OFS_IRQ_STAT, 32'h0000_000F, "irq status");
    rd(`DPA_OFS_IRQ_STAT, 32'h0000_0000, "irq status cleared");
    chk("irq masked out", 32'h0, {31'h0, o_irq});
    @(posedge i_clk);
    pat[2] <= ALV ^ 32'h0000_0001;
    tick(1);
    chk("alarm before latency", 32'hF, {28'h0, o_alarm});
    tick(1);
    chk("alarm masked bit", 32'hB, {28'h0, o_alarm});
    wr(`DPA_OFS_IRQ_MASK, 32'h0000_0004);
    wr(ra(2, `DPA_OFS_CTRL), 32'h0000_000B);
    tick(4);
    chk("alarm differs mode", 32'hF, {28'h0, o_alarm});
    chk("irq raised", 32'h1, {31'h0, o_irq});
    rd(`DPA_OFS_IRQ_STAT, 32'h0000_0004, "irq status differs");
    tick(1);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    rd(`DPA_OFS_FLAGS, 32'h0000_000F, "live flags");
    rd(8'h50, 32'h0000_0000, "unmapped read");
    wr(ra(0, `DPA_OFS_CMD), `DPA_CMD_PRESET);
    wr(ra(0, `DPA_OFS_CMD), `DPA_CMD_CARD);
    rd(ra(0, `DPA_OFS_ALARM), ALV & 32'h0000_00FF, "alarm after presets");
    rd(ra(0, `DPA_OFS_MASK), MKV & 32'h0000_00FF, "mask after presets");
    rd(ra(2, `DPA_OFS_CTRL), 32'h0000_000B, "ctrl after presets");
    chk("alarm after presets", 32'hF, {28'h0, o_alarm});
    wr(ra(1, `DPA_OFS_CMD), `DPA_CMD_FACTORY);
    for (int c = 0; c < `DPA_NUM_CH; c++) begin
      rd(ra(c, `DPA_OFS_ALARM), 32'h0000_0000, "alarm after factory");
      rd(ra(c, `DPA_OFS_MASK), 32'h0000_0000, "mask after factory");
      rd(ra(c, `DPA_OFS_CTRL), 32'h0000_0000, "ctrl after factory");
    end
    chk("alarm after factory", 32'h0, {28'h0, o_alarm});
    give_verdict();
  end
endmodule
`default_nettype wire
